// ==== hw/fbs_pkg.sv ====
// Shared constants for the fieldbus slave state machine and start-up gate
package fbs_pkg;

  // Slave communication state codes reported to the master
  localparam logic [3:0] FBS_CODE_INIT = 4'h1;
  localparam logic [3:0] FBS_CODE_PREOP = 4'h2;
  localparam logic [3:0] FBS_CODE_BOOT = 4'h3;
  localparam logic [3:0] FBS_CODE_SAFEOP = 4'h4;
  localparam logic [3:0] FBS_CODE_OP = 4'h8;

  // Reset values of the output images
  localparam logic [7:0] FBS_DATA_RESET = 8'h00;

  // Timing: the monitoring time is counted in milliseconds
  localparam int FBS_CLK_PERIOD_NS = 40;
  localparam int FBS_MS_NS = 1000000;
  localparam int FBS_MS_CYCLES = FBS_MS_NS / FBS_CLK_PERIOD_NS;

  // Widths
  localparam int FBS_DATA_W = 8;
  localparam int FBS_MON_W = 16;

  // Slave state machine, one-hot
  typedef enum logic [4:0] {
    FBS_S_INIT = 5'b00001,
    FBS_S_PREOP = 5'b00010,
    FBS_S_SAFEOP = 5'b00100,
    FBS_S_OP = 5'b01000,
    FBS_S_BOOT = 5'b10000
  } fbs_slave_e;

  // Start-up gate, one-hot
  typedef enum logic [3:0] {
    FBS_G_IDLE = 4'b0001,
    FBS_G_WAIT = 4'b0010,
    FBS_G_RUN = 4'b0100,
    FBS_G_STOP = 4'b1000
  } fbs_gate_e;

endpackage : fbs_pkg

// ==== hw/fbs_slave_sm.sv ====
// Fieldbus slave communication state machine with controller start-up gate
//
// How it works
// RULE1 - Initial state blocks mailbox and process data
// RULE2 - Master sets mailbox channels in initial state
// RULE3 - Check mailbox setup before entering pre-operational
// RULE4 - Pre-operational allows mailbox, blocks process data
// RULE5 - Master configures process data in pre-operational
// RULE6 - Check process data setup before safe-operational
// RULE7 - Copy inputs to memory before acknowledging
// RULE8 - Safe-operational refreshes inputs, outputs stay disabled
// RULE9 - Operational drives outputs from master data
// RULE10 - Bootstrap reachable only from initial state
// RULE11 - Bootstrap allows file-access mailbox only
// RULE12 - Master goes operational after start-up routine
// RULE13 - Wait for slaves up to monitoring time
// RULE14 - Strict mode runs only with good topology
// RULE15 - Tolerant mode runs regardless of topology
// RULE16 - Mismatch parameter selects strict start-up
// RULE17 - Wrong mandatory module blocks tolerant run
// RULE18 - Wrong optional module blocks tolerant run
// RULE19 - Unconfigured slave found blocks tolerant run
// RULE20 - Missing mandatory slave blocks tolerant run
// RULE21 - Clean bus runs regardless of optional slaves
// RULE22 - Only master requests change the state
// RULE23 - Step states in order, stay on failure
// RULE24 - Report current state code to master
`timescale 1ns/1ps
`default_nettype none

module fbs_slave_sm
  import fbs_pkg::*;
#(
  parameter int MS_CYCLES = FBS_MS_CYCLES
) (
  input wire logic clock_i,                        // System clock, 25 MHz
  input wire logic resetn_i,                       // Synchronous reset, active low
  input wire logic req_valid_i,                    // Master state request strobe
  input wire logic [3:0] req_state_i,              // Requested state code
  input wire logic mbx_cfg_ok_i,                   // Mailbox channels 0 and 1 set up
  input wire logic pd_cfg_ok_i,                    // Process data channels set up
  input wire logic [FBS_DATA_W-1:0] in_data_i,     // Local input values
  input wire logic [FBS_DATA_W-1:0] out_data_i,    // Output data from the master
  input wire logic startup_done_i,                 // Start-up routine has finished
  input wire logic [FBS_MON_W-1:0] monitor_ms_i,   // Monitoring time in ms
  input wire logic mismatch_start_i,               // Strict start-up, run only on matching topology
  input wire logic mand_slaves_op_i,               // Mandatory slaves are operational
  input wire logic topology_ok_i,                  // Topology matches configuration
  input wire logic mand_configured_i,              // Mandatory slaves configured
  input wire logic mand_exist_i,                   // All mandatory slaves exist
  input wire logic mand_wrong_i,                   // Mandatory slave with wrong module
  input wire logic opt_wrong_i,                    // Optional slave with wrong module
  input wire logic unconf_found_i,                 // Unconfigured slave found
  output logic [3:0] state_code_o,                 // Current state code
  output logic ack_o,                              // Request accepted, one cycle
  output logic refuse_o,                           // Request refused, one cycle
  output logic mbx_en_o,                           // Mailbox traffic allowed
  output logic foe_only_o,                         // Only file access mailbox allowed
  output logic pd_en_o,                            // Process data exchange allowed
  output logic outputs_en_o,                       // Physical outputs enabled
  output logic [FBS_DATA_W-1:0] dpm_in_o,          // Input image in dual port memory
  output logic [FBS_DATA_W-1:0] outputs_o,         // Physical outputs
  output logic master_op_o,                        // Master operational
  output logic run_o,                              // Main cyclic program may run
  output logic stop_o                              // Run mode refused
);

  fbs_slave_e state;
  fbs_slave_e next_state;
  logic accept;
  logic next_mbx_en;
  logic next_foe_only;
  logic next_pd_en;
  logic next_outputs_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Transition decode: only a master request moves the state

  always_comb begin
    next_state = state;
    accept = 1'b0;
    if (req_valid_i) begin // RULE22
      if (req_state_i == FBS_CODE_INIT) begin
        next_state = FBS_S_INIT;
        accept = 1'b1;
      end else begin
        case (state)
          FBS_S_INIT: begin
            if (req_state_i == FBS_CODE_PREOP && mbx_cfg_ok_i) begin // RULE3
              next_state = FBS_S_PREOP;
              accept = 1'b1;
            end else if (req_state_i == FBS_CODE_BOOT) begin // RULE10
              next_state = FBS_S_BOOT;
              accept = 1'b1;
            end
          end
          FBS_S_PREOP: begin
            if (req_state_i == FBS_CODE_PREOP) begin
              accept = 1'b1;
            end else if (req_state_i == FBS_CODE_SAFEOP && pd_cfg_ok_i) begin // RULE6 RULE23
              next_state = FBS_S_SAFEOP;
              accept = 1'b1;
            end
          end
          FBS_S_SAFEOP: begin
            if (req_state_i == FBS_CODE_PREOP) begin
              next_state = FBS_S_PREOP;
              accept = 1'b1;
            end else if (req_state_i == FBS_CODE_SAFEOP) begin
              accept = 1'b1;
            end else if (req_state_i == FBS_CODE_OP) begin // RULE23
              next_state = FBS_S_OP;
              accept = 1'b1;
            end
          end
          FBS_S_OP: begin
            if (req_state_i == FBS_CODE_PREOP) begin
              next_state = FBS_S_PREOP;
              accept = 1'b1;
            end else if (req_state_i == FBS_CODE_SAFEOP) begin
              next_state = FBS_S_SAFEOP;
              accept = 1'b1;
            end else if (req_state_i == FBS_CODE_OP) begin
              accept = 1'b1;
            end
          end
          FBS_S_BOOT: begin
            // Leaving bootstrap is only possible through the initial state
            accept = (req_state_i == FBS_CODE_BOOT); // RULE10
          end
          default: begin
            next_state = FBS_S_INIT;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register and acknowledge

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state <= FBS_S_INIT;
    end else begin
      state <= next_state; // RULE23
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req_valid_i && accept; // RULE24
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      refuse_o <= 1'b0;
    end else begin
      refuse_o <= req_valid_i && !accept; // RULE23
    end
  end

  // Code and ack change on the same edge, so the master sees the new code with the ack
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_code_o <= FBS_CODE_INIT;
    end else begin
      case (next_state)
        FBS_S_INIT: state_code_o <= FBS_CODE_INIT; // RULE24
        FBS_S_PREOP: state_code_o <= FBS_CODE_PREOP;
        FBS_S_SAFEOP: state_code_o <= FBS_CODE_SAFEOP;
        FBS_S_OP: state_code_o <= FBS_CODE_OP;
        FBS_S_BOOT: state_code_o <= FBS_CODE_BOOT;
        default: state_code_o <= FBS_CODE_INIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Communication services per state

  // Decoded from the next state so the enables switch on the same edge as the code
  always_comb begin
    case (next_state)
      FBS_S_INIT: begin
        next_mbx_en = 1'b0; // RULE1
        next_foe_only = 1'b0;
        next_pd_en = 1'b0; // RULE1
        next_outputs_en = 1'b0;
      end
      FBS_S_PREOP: begin
        next_mbx_en = 1'b1; // RULE4
        next_foe_only = 1'b0;
        next_pd_en = 1'b0; // RULE4
        next_outputs_en = 1'b0;
      end
      FBS_S_SAFEOP: begin
        next_mbx_en = 1'b1; // RULE8
        next_foe_only = 1'b0;
        next_pd_en = 1'b1; // RULE8
        next_outputs_en = 1'b0; // RULE8
      end
      FBS_S_OP: begin
        next_mbx_en = 1'b1; // RULE9
        next_foe_only = 1'b0;
        next_pd_en = 1'b1; // RULE9
        next_outputs_en = 1'b1; // RULE9
      end
      FBS_S_BOOT: begin
        // The mailbox is switched on, coming from init where it was off, but only for file access
        next_mbx_en = 1'b1; // RULE11
        next_foe_only = 1'b1; // RULE11
        next_pd_en = 1'b0; // RULE11
        next_outputs_en = 1'b0;
      end
      default: begin
        next_mbx_en = 1'b0;
        next_foe_only = 1'b0;
        next_pd_en = 1'b0;
        next_outputs_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      mbx_en_o <= 1'b0;
    end else begin
      mbx_en_o <= next_mbx_en;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      foe_only_o <= 1'b0;
    end else begin
      foe_only_o <= next_foe_only;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pd_en_o <= 1'b0;
    end else begin
      pd_en_o <= next_pd_en;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      outputs_en_o <= 1'b0;
    end else begin
      outputs_en_o <= next_outputs_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Process images

  // The input image is loaded on the same edge that enters safe-operational,
  // so it is valid in the same cycle as the ack pulse
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      dpm_in_o <= FBS_DATA_RESET;
    end else if (next_state == FBS_S_SAFEOP || next_state == FBS_S_OP) begin
      dpm_in_o <= in_data_i; // RULE7 RULE8
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      outputs_o <= FBS_DATA_RESET;
    end else if (next_state == FBS_S_OP) begin
      outputs_o <= out_data_i; // RULE9
    end else begin
      outputs_o <= FBS_DATA_RESET; // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Controller start-up gate

  fbs_startup_gate #(
    .MS_CYCLES(MS_CYCLES)
  ) u_gate (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .startup_done_i(startup_done_i),
    .monitor_ms_i(monitor_ms_i),
    .mismatch_start_i(mismatch_start_i),
    .mand_slaves_op_i(mand_slaves_op_i),
    .topology_ok_i(topology_ok_i),
    .mand_configured_i(mand_configured_i),
    .mand_exist_i(mand_exist_i),
    .mand_wrong_i(mand_wrong_i),
    .opt_wrong_i(opt_wrong_i),
    .unconf_found_i(unconf_found_i),
    .master_op_o(master_op_o),
    .run_o(run_o),
    .stop_o(stop_o)
  );

endmodule : fbs_slave_sm

`default_nettype wire

// ==== hw/fbs_startup_gate.sv ====
// Controller start-up gate: waits for slaves, then decides on run mode
`timescale 1ns/1ps
`default_nettype none

module fbs_startup_gate
  import fbs_pkg::*;
#(
  parameter int MS_CYCLES = FBS_MS_CYCLES
) (
  input wire logic clock_i,                       // System clock
  input wire logic resetn_i,                      // Synchronous reset, active low
  input wire logic startup_done_i,                // Start-up routine has finished
  input wire logic [FBS_MON_W-1:0] monitor_ms_i,  // Monitoring time in ms
  input wire logic mismatch_start_i,              // Strict start-up, run only on matching topology
  input wire logic mand_slaves_op_i,              // All mandatory slaves reached operational
  input wire logic topology_ok_i,                 // Found bus matches configuration
  input wire logic mand_configured_i,             // Mandatory slaves are configured
  input wire logic mand_exist_i,                  // All mandatory slaves were found
  input wire logic mand_wrong_i,                  // A mandatory slave has a wrong module
  input wire logic opt_wrong_i,                   // An optional slave has a wrong module
  input wire logic unconf_found_i,                // An unconfigured slave was found
  output logic master_op_o,                       // Master operational, requests op
  output logic run_o,                             // Main cyclic program may run
  output logic stop_o                             // Run mode refused
);

  fbs_gate_e state;
  fbs_gate_e next_state;
  logic [$clog2(MS_CYCLES+1)-1:0] tick_cnt;
  logic ms_tick;
  logic [FBS_MON_W-1:0] ms_cnt;
  logic timed_out;
  logic go_run;

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond enable and monitoring timer

  assign ms_tick = (tick_cnt == ($clog2(MS_CYCLES+1))'(MS_CYCLES - 1));
  assign timed_out = (ms_cnt >= monitor_ms_i);

  always_ff @(posedge clock_i) begin
    if (!resetn_i || state != FBS_G_WAIT || ms_tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i || state != FBS_G_WAIT) begin
      ms_cnt <= '0;
    end else if (ms_tick && !timed_out) begin
      ms_cnt <= ms_cnt + 1'b1; // RULE13
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Run decision

  always_comb begin
    if (mismatch_start_i) begin
      go_run = topology_ok_i; // RULE14 RULE16
    end else begin
      // Tolerant: any wrong module, stranger or missing mandatory slave blocks run
      go_run = !mand_wrong_i // RULE17
        && !opt_wrong_i // RULE18
        && !unconf_found_i // RULE19
        && !(mand_configured_i && !mand_exist_i); // RULE20 RULE21 RULE15
    end
  end

  always_comb begin
    case (state)
      FBS_G_IDLE: next_state = startup_done_i ? FBS_G_WAIT : FBS_G_IDLE; // RULE12
      FBS_G_WAIT: begin
        if (mand_slaves_op_i || timed_out) begin // RULE13
          next_state = go_run ? FBS_G_RUN : FBS_G_STOP;
        end else begin
          next_state = FBS_G_WAIT;
        end
      end
      FBS_G_RUN: next_state = FBS_G_RUN;
      FBS_G_STOP: next_state = FBS_G_STOP;
      default: next_state = FBS_G_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state <= FBS_G_IDLE;
      master_op_o <= 1'b0;
      run_o <= 1'b0;
      stop_o <= 1'b0;
    end else begin
      state <= next_state;
      master_op_o <= (next_state != FBS_G_IDLE); // RULE12
      run_o <= (next_state == FBS_G_RUN);
      stop_o <= (next_state == FBS_G_STOP);
    end
  end

endmodule : fbs_startup_gate

`default_nettype wire

// ==== tb/fbs_master_model.sv ====
// Behavioural bus master that issues state requests
`timescale 1ns/1ps
`default_nettype none
module fbs_master_model (
  input wire logic clock_i, // System clock
  output logic req_valid_o, // Request strobe
  output logic [3:0] req_state_o, // Requested code
  output logic mbx_cfg_ok_o, // Mailbox channels set up
  output logic pd_cfg_ok_o // Process data channels set up
);
  initial begin
    req_valid_o = 1'b0;
    req_state_o = 4'h0;
    mbx_cfg_ok_o = 1'b0;
    pd_cfg_ok_o = 1'b0;
  end
  task automatic request(input logic [3:0] code, input logic mbx, input logic pd);
    @(negedge clock_i);
    mbx_cfg_ok_o = mbx;
    pd_cfg_ok_o = pd;
    req_state_o = code;
    req_valid_o = 1'b1;
    @(negedge clock_i);
    req_valid_o = 1'b0;
    // Released code lines must not keep looking valid
    req_state_o = ~code;
  endtask : request
endmodule : fbs_master_model
`default_nettype wire

// ==== tb/fbs_slave_sm_monitor.sv ====
// Checker for the slave state machine and the start-up gate
`timescale 1ns/1ps
`default_nettype none
module fbs_slave_sm_monitor
  import fbs_pkg::*;
#(
  parameter int MS_CYCLES = 4
) (
  input wire logic clock_i, // Clock
  input wire logic resetn_i, // Reset
  input wire logic req_valid_i, // Request strobe
  input wire logic [3:0] req_state_i, // Requested code
  input wire logic mbx_cfg_ok_i, // Mailbox set up
  input wire logic pd_cfg_ok_i, // Process data set up
  input wire logic [FBS_DATA_W-1:0] out_data_i, // Master output data
  input wire logic [3:0] state_code_o, // State code
  input wire logic ack_o, // Accepted
  input wire logic refuse_o, // Refused
  input wire logic mbx_en_o, // Mailbox on
  input wire logic foe_only_o, // File access only
  input wire logic pd_en_o, // Process data on
  input wire logic outputs_en_o, // Outputs on
  input wire logic [FBS_DATA_W-1:0] outputs_o, // Outputs
  input wire logic master_op_o, // Master operational
  input wire logic run_o, // Run mode
  input wire logic stop_o // Run refused
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_op_twice;
    state_code_o == FBS_CODE_OP ##1 state_code_o == FBS_CODE_OP;
  endsequence
  property p_init; state_code_o == FBS_CODE_INIT |-> !mbx_en_o && !pd_en_o; endproperty
  a_init: assert property (p_init) else $error("init state leaks traffic");
  property p_mbx_chk;
    req_valid_i && state_code_o == FBS_CODE_INIT && req_state_i == FBS_CODE_PREOP
      && !mbx_cfg_ok_i |=> refuse_o && state_code_o == FBS_CODE_INIT;
  endproperty
  a_mbx_chk: assert property (p_mbx_chk) else $error("preop without mailbox");
  property p_preop;
    state_code_o == FBS_CODE_PREOP |-> mbx_en_o && !pd_en_o && !foe_only_o;
  endproperty
  a_preop: assert property (p_preop) else $error("preop enables wrong");
  property p_pd_chk;
    req_valid_i && state_code_o == FBS_CODE_PREOP && req_state_i == FBS_CODE_SAFEOP
      && !pd_cfg_ok_i |=> refuse_o && state_code_o == FBS_CODE_PREOP;
  endproperty
  a_pd_chk: assert property (p_pd_chk) else $error("safeop without pd setup");
  property p_safeop;
    state_code_o == FBS_CODE_SAFEOP |-> mbx_en_o && pd_en_o && !outputs_en_o;
  endproperty
  a_safeop: assert property (p_safeop) else $error("safeop enables wrong");
  property p_op_out; s_op_twice |-> outputs_en_o && outputs_o == $past(out_data_i); endproperty
  a_op_out: assert property (p_op_out) else $error("op outputs wrong");
  property p_boot_gate;
    req_valid_i && req_state_i == FBS_CODE_BOOT && state_code_o != FBS_CODE_INIT
      && state_code_o != FBS_CODE_BOOT |=> refuse_o;
  endproperty
  a_boot_gate: assert property (p_boot_gate) else $error("boot taken late");
  property p_boot; state_code_o == FBS_CODE_BOOT |-> foe_only_o && !pd_en_o; endproperty
  a_boot: assert property (p_boot) else $error("boot enables wrong");
  property p_quiet; !req_valid_i |=> $stable(state_code_o); endproperty
  a_quiet: assert property (p_quiet) else $error("state moved unasked");
  property p_answer; req_valid_i |=> ack_o != refuse_o; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_run_cause; $rose(run_o) |-> $past(master_op_o) && !stop_o; endproperty
  a_run_cause: assert property (p_run_cause) else $error("run before master op");
endmodule : fbs_slave_sm_monitor
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the slave state machine
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fbs_pkg::*;
  localparam int MS = 4;
  logic clock_i, resetn_i, rv, mok, pok, sdone, mis, topo, mcfg, mex, mw, ow, unc, mop;
  logic [3:0] rs, code;
  logic [7:0] ind, outd, dpm, outs;
  logic ack, ref_, mbx, foe, pde, oen, mst, run, stp;
  int err_count = 0;
  int checks_done = 0;
  int n;
  logic [11:0] rows [13] = '{12'h401, 12'h201, 12'h2A2, 12'h882, 12'h382, 12'h482, 12'h4E4,
    12'h8E8, 12'h1E1, 12'h3E3, 12'h2C3, 12'h1E1, 12'h5C1};
  logic [8:0] grows [8] = '{9'b110000001, 9'b101100000, 9'b001100001, 9'b001110000,
    9'b001101000, 9'b001100100, 9'b001000000, 9'b000000011};
  fbs_master_model pm (.clock_i(clock_i), .req_valid_o(rv), .req_state_o(rs),
    .mbx_cfg_ok_o(mok), .pd_cfg_ok_o(pok));
  fbs_slave_sm #(.MS_CYCLES(MS)) dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .req_valid_i(rv), .req_state_i(rs), .mbx_cfg_ok_i(mok), .pd_cfg_ok_i(pok),
    .in_data_i(ind), .out_data_i(outd), .startup_done_i(sdone), .monitor_ms_i(16'h0002),
    .mismatch_start_i(mis), .mand_slaves_op_i(mop), .topology_ok_i(topo),
    .mand_configured_i(mcfg), .mand_exist_i(mex), .mand_wrong_i(mw), .opt_wrong_i(ow),
    .unconf_found_i(unc), .state_code_o(code), .ack_o(ack), .refuse_o(ref_),
    .mbx_en_o(mbx), .foe_only_o(foe), .pd_en_o(pde), .outputs_en_o(oen), .dpm_in_o(dpm),
    .outputs_o(outs), .master_op_o(mst), .run_o(run), .stop_o(stp));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic do_reset();
    @(negedge clock_i);
    resetn_i = 1'b0;
    repeat (8) @(negedge clock_i);
    resetn_i = 1'b1;
  endtask : do_reset
  function automatic logic [7:0] en_of(input logic [3:0] c);
    case (c)
      4'h2: return 8'h08;
      4'h4: return 8'h0A;
      4'h8: return 8'h0B;
      4'h3: return 8'h0C;
      default: return 8'h00;
    endcase
  endfunction : en_of
  initial begin
    {resetn_i, sdone, mis, topo, mcfg, mex, mw, ow, unc, mop} = '0;
    ind = 8'hA5;
    outd = 8'h5A;
    do_reset();
    chk("reset code", 8'h01, {4'h0, code});
    chk("reset outputs", 8'h00, {ack, ref_, mbx, foe, pde, oen, mst, run});
    chk("reset images", 8'h00, dpm | outs | {7'h00, stp});
    $display("reset test done");
    foreach (rows[i]) begin
      pm.request(rows[i][11:8], rows[i][7], rows[i][6]);
      chk("ack", {7'h00, rows[i][5]}, {7'h00, ack});
      chk("refuse", {7'h00, ~rows[i][5]}, {7'h00, ref_});
      chk("code", {4'h0, rows[i][3:0]}, {4'h0, code});
      chk("enables", en_of(rows[i][3:0]), {4'h0, mbx, foe, pde, oen});
      if (rows[i][3:0] == FBS_CODE_SAFEOP) chk("input copy", 8'hA5, dpm);
      if (rows[i][3:0] == FBS_CODE_OP) chk("outputs", 8'h5A, outs);
      $display("request row %0d done", i);
    end
    pm.request(4'h2, 1'b1, 1'b1);
    pm.request(4'h4, 1'b1, 1'b1);
    chk("safeop outputs", 8'h00, outs);
    ind = 8'h3C;
    repeat (2) @(negedge clock_i);
    chk("input refresh", 8'h3C, dpm);
    $display("safeop refresh test done");
    foreach (grows[i]) begin
      do_reset();
      {mis, topo, mcfg, mex, mw, ow, unc} = grows[i][8:2];
      mop = ~grows[i][1];
      chk("reset master op", 8'h00, {7'h00, mst});
      sdone = 1'b1;
      n = 0;
      while (!(run || stp) && n < 40) begin
        @(negedge clock_i);
        n++;
      end
      chk("master op", 8'h01, {7'h00, mst});
      chk("run", {7'h00, grows[i][0]}, {7'h00, run});
      chk("stop", {7'h00, ~grows[i][0]}, {7'h00, stp});
      if (grows[i][1]) chk("wait long", 8'h01, {7'h00, n >= 2 * MS});
      sdone = 1'b0;
      $display("gate row %0d done", i);
    end
    end_sim();
  end
  initial begin
    #(40 * 3000);
    err_count++;
    end_sim();
  end
endmodule : tb
bind fbs_slave_sm fbs_slave_sm_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.clock_i(clock_i),
  .resetn_i(resetn_i), .req_valid_i(req_valid_i), .req_state_i(req_state_i),
  .mbx_cfg_ok_i(mbx_cfg_ok_i), .pd_cfg_ok_i(pd_cfg_ok_i), .out_data_i(out_data_i),
  .state_code_o(state_code_o), .ack_o(ack_o), .refuse_o(refuse_o), .mbx_en_o(mbx_en_o),
  .foe_only_o(foe_only_o), .pd_en_o(pd_en_o), .outputs_en_o(outputs_en_o),
  .outputs_o(outputs_o), .master_op_o(master_op_o), .run_o(run_o), .stop_o(stop_o));
`default_nettype wire
